/* File: src/amcd_pkg.sv */
// Package for the analog module command decoder.
// Assumes one 125 MHz clock domain shared by all users.
package amcd_pkg;
  // Memory type codes, word mode
  localparam logic [7:0] MT_REG = 8'h08;
  localparam logic [7:0] MT_AIN = 8'h0A;
  localparam logic [7:0] MT_AOUT = 8'h0C;
  localparam logic [7:0] MT_WORD = 8'hC4;
  // Byte mode discrete
  localparam logic [7:0] MT_IN_B = 8'h10;
  localparam logic [7:0] MT_OUT_B = 8'h12;
  localparam logic [7:0] MT_TMP_B = 8'h14;
  localparam logic [7:0] MT_MOM_B = 8'h16;
  localparam logic [7:0] MT_GLB_B = 8'h38;
  // Bit mode discrete
  localparam logic [7:0] MT_IN_BIT = 8'h46;
  localparam logic [7:0] MT_OUT_BIT = 8'h48;
  localparam logic [7:0] MT_TMP_BIT = 8'h4A;
  localparam logic [7:0] MT_MOM_BIT = 8'h4C;
  localparam logic [7:0] MT_GLB_BIT = 8'h56;
  // Highest zero-based offset of general word memory
  localparam logic [15:0] WORD_OFS_MAX = 16'hFFFF;
  localparam logic [15:0] CMD_DATA_BYTES = 16'h0006;

  // Command code groups (high nibble of low byte)
  localparam logic [15:0] CMD_LO_SET = 16'h0000;
  localparam logic [15:0] CMD_HI_SET = 16'h0010;
  localparam logic [15:0] CMD_LO_ADJ = 16'h0020;
  localparam logic [15:0] CMD_HI_ADJ = 16'h0030;
  localparam logic [15:0] CMD_RAMP_OFF = 16'h0040;
  localparam logic [15:0] CMD_RAMP_STEP = 16'h0050;
  localparam logic [15:0] CMD_RAMP_TIME = 16'h0060;
  localparam logic [15:0] CMD_CLR_ERR = 16'h00C0;
  localparam logic [15:0] RAMP_ARG_MAX = 16'h7D00;

  // Completion status values, both non-zero
  localparam logic [15:0] STAT_OK = 16'h0001;
  localparam logic [15:0] STAT_FAIL = 16'h0002;
  // Error codes shown on o_err_code, not in the status word
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_BAD_LIMIT = 8'h02;
  localparam logic [7:0] ERR_BAD_RAMP = 8'h03;
  localparam logic [7:0] ERR_BAD_AREA = 8'h04;

  // Alarm limit legal ranges
  localparam logic signed [15:0] LO_MAX = 16'sh7FF7;
  localparam logic signed [15:0] HI_MIN = -16'sh7FFF;
  localparam logic signed [15:0] HI_MAX = 16'sh7FF8;

  localparam int N_IN = 4;
  localparam int N_OUT = 2;

  // Timing: one millisecond tick
  localparam int CLK_MHZ = 125;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;

  typedef enum logic [1:0] {RAMP_NORMAL, RAMP_STEP, RAMP_TIME} amcd_ramp_t;

  typedef struct packed {
    logic [7:0] status_type;
    logic [15:0] status_ofs;
    logic [15:0] data_len;
    logic [7:0] data_type;
    logic [15:0] data_ofs;
    logic [15:0] cmd_word;
    logic [15:0] arg_word;
    logic [15:0] spare_word;
  } amcd_req_t;

  typedef struct packed {
    logic [7:0] status_type;
    logic [15:0] status_ofs;
    logic [15:0] status_word;
  } amcd_done_t;
endpackage : amcd_pkg

/* File: src/amcd_decoder.sv */
// Command decoder of a four-input, two-output mixed analog module.
// Assumes the requester has already fetched the command block and data
// and presents them as one request; writes back through o_done.
//
// Overview of operation
// - Word-mode area codes are 08H, 0AH and 0CH for status and data.
// - Byte-mode discrete codes are 10H, 12H, 14H, 16H and 38H.
// - Bit-mode discrete codes are 46H, 48H, 4AH, 4CH and 56H.
// - Code C4H selects general word memory, word addresses 1 to 65536.
// - Status and data offsets are zero based.
// - Command data is three words; code, argument, third word ignored.
// - Codes 0000-0003 load low alarm limit of inputs one to four.
// - Codes 0010-0013 load high alarm limit of inputs one to four.
// - Codes 0020-0023 add signed increment to low alarm limit.
// - Codes 0030-0033 add signed increment to high alarm limit.
// - Codes 0040-0041 cancel ramping, output returns to direct update.
// - Codes 0050-0051 step ramp, 1 to 32000 counts per millisecond.
// - Codes 0060-0061 timed ramp over 1 to 32000 milliseconds.
// - Code 00C0 clears the posted error code.
// - Invalid requests change nothing and post an error code.
// - An error code never halts inputs or outputs.
// - Error code stays until clear command or reconfiguration.
// - Every completed request returns a non-zero status word.
// - Ramp off mid-ramp drives output straight to its commanded value.
// - Step to timed ramp restarts from present output and time.
// - Ramp command with bad channel, step or time posts error.
// - Low alarm limit stays strictly below high alarm limit.
`timescale 1ns/1ps
`default_nettype none

module amcd_decoder (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire amcd_pkg::amcd_req_t i_req,
  input wire logic i_reconfig,
  input wire logic [amcd_pkg::N_IN*16-1:0] i_cfg_lo,
  input wire logic [amcd_pkg::N_IN*16-1:0] i_cfg_hi,
  input wire logic [amcd_pkg::N_OUT*16-1:0] i_out_cmd,
  output logic o_done_valid,
  output amcd_pkg::amcd_done_t o_done,
  output logic [7:0] o_err_code,
  output logic [amcd_pkg::N_IN*16-1:0] o_lo_limit,
  output logic [amcd_pkg::N_IN*16-1:0] o_hi_limit,
  output logic [amcd_pkg::N_OUT*16-1:0] o_out_value,
  output logic [amcd_pkg::N_OUT*2-1:0] o_ramp_mode
);
  localparam int N_IN = amcd_pkg::N_IN;
  localparam int N_OUT = amcd_pkg::N_OUT;

  function automatic logic word_area(input logic [7:0] t);
    word_area = (t == amcd_pkg::MT_REG) || (t == amcd_pkg::MT_AIN)
      || (t == amcd_pkg::MT_AOUT) || (t == amcd_pkg::MT_WORD);
  endfunction : word_area

  // Status may land in any area, the data block only in a word area
  function automatic logic any_area(input logic [7:0] t);
    any_area = word_area(t)
      || (t == amcd_pkg::MT_IN_B) || (t == amcd_pkg::MT_OUT_B)
      || (t == amcd_pkg::MT_TMP_B) || (t == amcd_pkg::MT_MOM_B) || (t == amcd_pkg::MT_GLB_B)
      || (t == amcd_pkg::MT_IN_BIT) || (t == amcd_pkg::MT_OUT_BIT)
      || (t == amcd_pkg::MT_TMP_BIT) || (t == amcd_pkg::MT_MOM_BIT) || (t == amcd_pkg::MT_GLB_BIT);
  endfunction : any_area

  // Alarm limit groups, shared by the decode and the limit update
  function automatic logic lo_group(input logic [15:0] g);
    lo_group = (g == amcd_pkg::CMD_LO_SET) || (g == amcd_pkg::CMD_LO_ADJ);
  endfunction : lo_group

  function automatic logic hi_group(input logic [15:0] g);
    hi_group = (g == amcd_pkg::CMD_HI_SET) || (g == amcd_pkg::CMD_HI_ADJ);
  endfunction : hi_group

  // Zero-based offsets need no bias; 16 bits cover word addresses 1..65536
  logic area_ok;
  always_comb
  begin
    area_ok = any_area(i_req.status_type) && word_area(i_req.data_type)
      && (i_req.data_len == amcd_pkg::CMD_DATA_BYTES)
      && (i_req.data_ofs <= amcd_pkg::WORD_OFS_MAX);
  end

  // Decode of the command word; the spare word is never looked at
  logic [15:0] grp;
  logic [1:0] ch;
  logic signed [15:0] arg;
  logic signed [16:0] lo_sum;
  logic signed [16:0] hi_sum;
  logic lo_ovf;
  logic hi_ovf;
  logic signed [15:0] new_lim;
  logic signed [15:0] cur_lo;
  logic signed [15:0] cur_hi;
  logic [7:0] err;
  always_comb
  begin
    grp = {i_req.cmd_word[15:4], 4'h0};
    ch = i_req.cmd_word[1:0];
    arg = $signed(i_req.arg_word);
    cur_lo = $signed(o_lo_limit[ch*16 +: 16]);
    cur_hi = $signed(o_hi_limit[ch*16 +: 16]);
    lo_sum = 17'(cur_lo) + 17'(arg);
    hi_sum = 17'(cur_hi) + 17'(arg);
    // A sum whose two top bits differ no longer fits a signed word
    lo_ovf = lo_sum[16] != lo_sum[15];
    hi_ovf = hi_sum[16] != hi_sum[15];
    new_lim = arg;
    err = amcd_pkg::ERR_NONE;
    if (!area_ok)
      err = amcd_pkg::ERR_BAD_AREA;
    else if (i_req.cmd_word == amcd_pkg::CMD_CLR_ERR)
      err = amcd_pkg::ERR_NONE;
    else if (lo_group(grp) && i_req.cmd_word[3:2] == 2'b00)
    begin
      if (grp == amcd_pkg::CMD_LO_ADJ)
        new_lim = lo_sum[15:0];
      if ((grp == amcd_pkg::CMD_LO_ADJ && lo_ovf)
          || new_lim > amcd_pkg::LO_MAX || new_lim >= cur_hi)
        err = amcd_pkg::ERR_BAD_LIMIT;
    end
    else if (hi_group(grp) && i_req.cmd_word[3:2] == 2'b00)
    begin
      if (grp == amcd_pkg::CMD_HI_ADJ)
        new_lim = hi_sum[15:0];
      if ((grp == amcd_pkg::CMD_HI_ADJ && hi_ovf)
          || new_lim > amcd_pkg::HI_MAX || new_lim < amcd_pkg::HI_MIN || new_lim <= cur_lo)
        err = amcd_pkg::ERR_BAD_LIMIT;
    end
    else if ((grp == amcd_pkg::CMD_RAMP_OFF || grp == amcd_pkg::CMD_RAMP_STEP
              || grp == amcd_pkg::CMD_RAMP_TIME))
    begin
      // Output channel sits in bit 0; bits 3 to 1 must be zero
      if (i_req.cmd_word[3:1] != 3'h0)
        err = amcd_pkg::ERR_BAD_RAMP;
      else if (grp != amcd_pkg::CMD_RAMP_OFF && (arg < 16'sh0001 || arg > $signed(amcd_pkg::RAMP_ARG_MAX)))
        err = amcd_pkg::ERR_BAD_RAMP;
    end
    else
      err = amcd_pkg::ERR_BAD_CMD;
  end

  // One request a cycle; the requester paces itself on the completion
  logic take;
  assign take = i_ce && i_req_valid;

  // Completion word always written back, never zero
  // The echoed status location tells the requester where the word belongs
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_done_valid <= 1'b0;
      o_done <= '0;
    end
    else if (i_ce)
    begin
      o_done_valid <= i_req_valid;
      if (i_req_valid)
      begin
        o_done.status_type <= i_req.status_type;
        o_done.status_ofs <= i_req.status_ofs;
        o_done.status_word <= (err == amcd_pkg::ERR_NONE) ? amcd_pkg::STAT_OK : amcd_pkg::STAT_FAIL;
      end
    end
  end

  // Error code is sticky; operation carries on regardless
  // A reconfiguration in the same cycle as a new error wins, so that refusal is not posted
  always_ff @(posedge i_clk)
  begin
    if (i_srst || (i_ce && i_reconfig))
      o_err_code <= amcd_pkg::ERR_NONE;
    else if (take && err != amcd_pkg::ERR_NONE)
      o_err_code <= err;
    else if (take && area_ok && i_req.cmd_word == amcd_pkg::CMD_CLR_ERR)
      o_err_code <= amcd_pkg::ERR_NONE;
  end

  // Alarm limits: configured values restored on reset or reconfiguration
  // A refused change leaves both limits as they were
  always_ff @(posedge i_clk)
  begin
    if (i_srst || (i_ce && i_reconfig))
    begin
      o_lo_limit <= i_cfg_lo;
      o_hi_limit <= i_cfg_hi;
    end
    else if (take && err == amcd_pkg::ERR_NONE)
    begin
      if (lo_group(grp))
        o_lo_limit[ch*16 +: 16] <= new_lim;
      else if (hi_group(grp))
        o_hi_limit[ch*16 +: 16] <= new_lim;
    end
  end

  // Shared one millisecond tick
  // Fires on the first enabled cycle after reset, then once a millisecond
  logic [$clog2(amcd_pkg::RAMP_TICK_CYC)-1:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == '0);
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      tick_cnt_reg <= '0;
    else if (i_ce)
      tick_cnt_reg <= tick ? ($bits(tick_cnt_reg))'(amcd_pkg::RAMP_TICK_CYC - 1) : tick_cnt_reg - 1'b1;
  end

  // Ramp engines; mode survives reconfiguration, lost only at reset
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++)
    begin : g_out
      amcd_pkg::amcd_ramp_t mode_reg;
      logic [15:0] step_reg;
      logic [15:0] time_reg;
      logic [15:0] left_reg;
      logic signed [15:0] tgt_reg;
      logic signed [15:0] val;
      logic signed [15:0] tgt;
      // Distance still to go, one bit wider so that it cannot wrap
      logic signed [16:0] diff;
      logic signed [16:0] stepv;
      logic hit;
      logic sel;
      assign val = $signed(o_out_value[g*16 +: 16]);
      assign tgt = $signed(i_out_cmd[g*16 +: 16]);
      assign diff = 17'(tgt) - 17'(val);
      assign sel = take && err == amcd_pkg::ERR_NONE && i_req.cmd_word[0] == 1'(g);
      // Timed ramp spreads what is left evenly over the remaining ticks
      always_comb
      begin
        if (mode_reg == amcd_pkg::RAMP_TIME)
          stepv = (left_reg <= 16'h0001) ? diff : 17'(diff / $signed({1'b0, left_reg}));
        else
          stepv = (diff > $signed({1'b0, step_reg})) ? $signed({1'b0, step_reg}) :
                  (diff < -$signed({1'b0, step_reg})) ? -$signed({1'b0, step_reg}) : diff;
        hit = (stepv == diff);
      end
      always_ff @(posedge i_clk)
      begin
        if (i_srst)
        begin
          mode_reg <= amcd_pkg::RAMP_NORMAL;
          step_reg <= '0;
          time_reg <= '0;
          left_reg <= '0;
          tgt_reg <= '0;
          o_out_value[g*16 +: 16] <= '0;
        end
        else if (i_ce)
        begin
          tgt_reg <= tgt;
          if (sel && grp == amcd_pkg::CMD_RAMP_OFF)
          begin
            mode_reg <= amcd_pkg::RAMP_NORMAL;
            o_out_value[g*16 +: 16] <= tgt;
          end
          else if (sel && grp == amcd_pkg::CMD_RAMP_STEP)
          begin
            mode_reg <= amcd_pkg::RAMP_STEP;
            step_reg <= i_req.arg_word;
          end
          else if (sel && grp == amcd_pkg::CMD_RAMP_TIME)
          begin
            mode_reg <= amcd_pkg::RAMP_TIME;
            time_reg <= i_req.arg_word;
            left_reg <= i_req.arg_word;
          end
          else if (mode_reg == amcd_pkg::RAMP_NORMAL)
            o_out_value[g*16 +: 16] <= tgt;
          else
          begin
            // A new commanded value restarts the timed ramp over the full time
            if (mode_reg == amcd_pkg::RAMP_TIME && tgt != tgt_reg)
              left_reg <= time_reg;
            else if (tick && !hit)
            begin
              o_out_value[g*16 +: 16] <= 16'(val + stepv[15:0]);
              if (left_reg > 16'h0001)
                left_reg <= left_reg - 16'h0001;
            end
            else if (tick)
              o_out_value[g*16 +: 16] <= tgt;
          end
        end
      end
      // Shown one cycle behind the internal mode
      always_ff @(posedge i_clk)
      begin
        if (i_srst)
          o_ramp_mode[g*2 +: 2] <= 2'h0;
        else if (i_ce)
          o_ramp_mode[g*2 +: 2] <= mode_reg;
      end
    end
  endgenerate
endmodule : amcd_decoder

`default_nettype wire

/* File: verification/amcd_props.sv */
// Assertion checker for the command decoder, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module amcd_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_req_valid,
  input wire amcd_pkg::amcd_req_t i_req,
  input wire logic i_reconfig,
  input wire logic o_done_valid,
  input wire amcd_pkg::amcd_done_t o_done,
  input wire logic [7:0] o_err_code,
  input wire logic [63:0] o_lo_limit,
  input wire logic [63:0] o_hi_limit,
  input wire logic [3:0] o_ramp_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_take; i_ce && i_req_valid; endsequence
  sequence s_ok; o_done_valid && i_ce && o_done.status_word == amcd_pkg::STAT_OK; endsequence
  sequence s_fail; o_done_valid && o_done.status_word == amcd_pkg::STAT_FAIL; endsequence
  property p_done_lat; s_take |=> o_done_valid; endproperty
  a_done_lat: assert property (p_done_lat) else $error("no completion after request");
  property p_no_spont; i_ce && !i_req_valid |=> !o_done_valid; endproperty
  a_no_spont: assert property (p_no_spont) else $error("completion without request");
  property p_stat_nz; o_done_valid |-> (o_done.status_word == amcd_pkg::STAT_OK) || (o_done.status_word == amcd_pkg::STAT_FAIL); endproperty
  a_stat_nz: assert property (p_stat_nz) else $error("bad status word");
  property p_echo; s_take |=> o_done.status_type == $past(i_req.status_type) && o_done.status_ofs == $past(i_req.status_ofs); endproperty
  a_echo: assert property (p_echo) else $error("status location not echoed");
  property p_err_hold; !(i_req_valid || i_reconfig) |=> $stable(o_err_code); endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code moved");
  property p_fail_keep; (s_take and !i_reconfig) ##1 s_fail |-> $stable(o_lo_limit) && $stable(o_hi_limit); endproperty
  a_fail_keep: assert property (p_fail_keep) else $error("refused request changed limits");
  property p_fail_err; s_fail |-> o_err_code != amcd_pkg::ERR_NONE; endproperty
  a_fail_err: assert property (p_fail_err) else $error("refusal without error code");
  property p_clr; s_take and (i_req.cmd_word == amcd_pkg::CMD_CLR_ERR && !i_reconfig)
    |=> s_fail or (o_err_code == amcd_pkg::ERR_NONE); endproperty
  a_clr: assert property (p_clr) else $error("error code not cleared");
  property p_order0; $signed(o_lo_limit[15:0]) < $signed(o_hi_limit[15:0]); endproperty
  a_order0: assert property (p_order0) else $error("low limit not below high");
  property p_set_lo0; (s_take and i_req.cmd_word == amcd_pkg::CMD_LO_SET) ##1 s_ok |-> o_lo_limit[15:0] == $past(i_req.arg_word); endproperty
  a_set_lo0: assert property (p_set_lo0) else $error("low limit not loaded");
  property p_step0; (s_take and i_req.cmd_word == amcd_pkg::CMD_RAMP_STEP) ##1 s_ok |=> o_ramp_mode[1:0] == 2'h1; endproperty
  a_step0: assert property (p_step0) else $error("step mode not shown");
endmodule : amcd_props
`default_nettype wire

/* File: verification/amcd_cpu_model.sv */
// Requester model: issues one command request and waits for its answer.
// Assumes the decoder answers on i_done_valid within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module amcd_cpu_model (
  input wire logic i_clk,
  input wire logic i_done_valid,
  input wire amcd_pkg::amcd_done_t i_done,
  output logic o_req_valid,
  output amcd_pkg::amcd_req_t o_req
);
  initial
  begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  task automatic issue(input logic [7:0] st, input logic [15:0] so, input logic [7:0] dt, input logic [15:0] len,
    input logic [15:0] cmd, input logic [15:0] arg, output logic [15:0] stat);
    int n;
    @(posedge i_clk);
    #1;
    o_req_valid = 1'b1;
    o_req = {st, so, len, dt, 16'h0064, cmd, arg, 16'hA5A5};
    @(posedge i_clk);
    #1;
    o_req_valid = 1'b0;
    // Released fields carry garbage so that nothing may be read from them late
    o_req = ~o_req;
    n = 0;
    while (i_done_valid !== 1'b1 && n < 8)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    stat = (i_done_valid === 1'b1) ? i_done.status_word : 16'h0000;
  endtask : issue
endmodule : amcd_cpu_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the command decoder.
// Assumes the requester model and checker sit beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [15:0] cmd; logic [15:0] arg; logic [15:0] stat; logic [7:0] err;
    logic [2:0] sel; logic [15:0] lim;} amcd_row_t;
  localparam logic [15:0] S_OK = amcd_pkg::STAT_OK;
  localparam logic [15:0] S_NG = amcd_pkg::STAT_FAIL;
  localparam logic [7:0] E_NO = amcd_pkg::ERR_NONE;
  localparam logic [7:0] E_LIM = amcd_pkg::ERR_BAD_LIMIT;
  localparam logic [7:0] E_CMD = amcd_pkg::ERR_BAD_CMD;
  localparam logic [7:0] E_RMP = amcd_pkg::ERR_BAD_RAMP;
  localparam logic [7:0] MR = amcd_pkg::MT_REG;
  logic clk, srst, ce, req_valid, reconfig, done_valid;
  amcd_pkg::amcd_req_t req;
  amcd_pkg::amcd_done_t done;
  logic [63:0] cfg_lo, cfg_hi, lo, hi;
  logic [31:0] out_cmd, outv;
  logic [7:0] err_code;
  logic [3:0] mode;
  int bad_count = 0;
  int cmp_count = 0;
  // Inputs one to four: low -100, high 1000..1003
  amcd_row_t rows [0:15] = '{
    '{16'h0000, 16'h0032, S_OK, E_NO, 3'h0, 16'h0032},
    '{16'h0013, 16'h07D0, S_OK, E_NO, 3'h7, 16'h07D0},
    '{16'h0021, 16'hFFFB, S_OK, E_NO, 3'h1, 16'hFF97},
    '{16'h0032, 16'h0007, S_OK, E_NO, 3'h6, 16'h03F1},
    '{16'h0040, 16'h0000, S_OK, E_NO, 3'h0, 16'h0032},
    '{16'h0051, 16'h7D00, S_OK, E_NO, 3'h0, 16'h0032},
    '{16'h0060, 16'h0001, S_OK, E_NO, 3'h0, 16'h0032},
    '{16'h00C0, 16'h0000, S_OK, E_NO, 3'h0, 16'h0032},
    '{16'h0050, 16'h0000, S_NG, E_RMP, 3'h0, 16'h0032},
    '{16'h0061, 16'h7D01, S_NG, E_RMP, 3'h0, 16'h0032},
    '{16'h0070, 16'h0000, S_NG, E_CMD, 3'h0, 16'h0032},
    '{16'h0002, 16'h0000, S_OK, E_CMD, 3'h2, 16'h0000},
    '{16'h0001, 16'h07D0, S_NG, E_LIM, 3'h1, 16'hFF97},
    '{16'h0010, 16'hFF38, S_NG, E_LIM, 3'h4, 16'h03E8},
    '{16'h0033, 16'h7FFF, S_NG, E_LIM, 3'h7, 16'h07D0},
    '{16'h00C0, 16'h0000, S_OK, E_NO, 3'h7, 16'h07D0}};
  logic [7:0] ty [0:13] = '{8'h08, 8'h0A, 8'h0C, 8'hC4, 8'h10, 8'h12, 8'h14, 8'h16, 8'h38,
    8'h46, 8'h48, 8'h4A, 8'h4C, 8'h56};
  amcd_decoder i_amcd_decoder (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_req_valid(req_valid), .i_req(req),
    .i_reconfig(reconfig), .i_cfg_lo(cfg_lo), .i_cfg_hi(cfg_hi), .i_out_cmd(out_cmd), .o_done_valid(done_valid),
    .o_done(done), .o_err_code(err_code), .o_lo_limit(lo), .o_hi_limit(hi), .o_out_value(outv), .o_ramp_mode(mode));
  amcd_cpu_model i_amcd_cpu_model (.i_clk(clk), .i_done_valid(done_valid), .i_done(done), .o_req_valid(req_valid),
    .o_req(req));
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic req_at(input logic [7:0] st, input logic [7:0] dt, input logic [15:0] len, input logic [15:0] cmd,
    input logic [15:0] arg, input logic [15:0] stat, input logic [7:0] err);
    logic [15:0] got;
    i_amcd_cpu_model.issue(st, 16'hFFFF, dt, len, cmd, arg, got);
    check_val(got, stat);
    check_val(err_code, err);
    check_val({done.status_type, done.status_ofs}, {st, 16'hFFFF});
  endtask : req_at
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // About 95 cycles are needed; the 12500-cycle limit leaves a wide margin
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    reconfig = 1'b0;
    out_cmd = '0;
    cfg_lo = {4{16'hFF9C}};
    cfg_hi = {16'h03EB, 16'h03EA, 16'h03E9, 16'h03E8};
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    check_val({lo, hi}, {cfg_lo, cfg_hi});
    check_val({outv, mode, err_code, done_valid}, '0);
    foreach (rows[i])
    begin
      req_at(MR, MR, 16'h0006, rows[i].cmd, rows[i].arg, rows[i].stat, rows[i].err);
      check_val(({hi, lo} >> (16 * rows[i].sel)) & 128'hFFFF, rows[i].lim);
    end
    check_val(mode, 4'h6);
    out_cmd = 32'h1234_0BCD;
    req_at(MR, MR, 16'h0006, 16'h0041, 16'h0000, S_OK, E_NO);
    repeat (2) @(posedge clk);
    #1;
    check_val(outv[31:16], 16'h1234);
    req_at(MR, MR, 16'h0006, 16'h0070, 16'h0000, S_NG, E_CMD);
    req_at(MR, MR, 16'h0006, 16'h0040, 16'h0000, S_OK, E_CMD);
    out_cmd[15:0] = 16'h0BCF;
    repeat (3) @(posedge clk);
    #1;
    check_val({outv[15:0], err_code}, {16'h0BCF, E_CMD});
    req_at(MR, MR, 16'h0006, 16'h0050, 16'h0005, S_OK, E_CMD);
    for (int i = 0; i < 14; i++)
      req_at(ty[i], (i < 4) ? ty[i] : MR, 16'h0006, 16'h00C0, 16'h0000, S_OK, E_NO);
    req_at(MR, amcd_pkg::MT_IN_B, 16'h0006, 16'h00C0, 16'h0000, S_NG, amcd_pkg::ERR_BAD_AREA);
    req_at(MR, MR, 16'h0004, 16'h00C0, 16'h0000, S_NG, amcd_pkg::ERR_BAD_AREA);
    req_at(MR, MR, 16'h0006, 16'h0003, 16'h0010, S_OK, amcd_pkg::ERR_BAD_AREA);
    @(posedge clk);
    #1;
    reconfig = 1'b1;
    @(posedge clk);
    #1;
    reconfig = 1'b0;
    check_val({lo, hi, err_code}, {cfg_lo, cfg_hi, E_NO});
    check_val(mode, 4'h1);
    // With the enable low a request must be neither taken nor answered
    ce = 1'b0;
    req_at(MR, MR, 16'h0006, 16'h0000, 16'h0005, 16'h0000, E_NO);
    ce = 1'b1;
    check_val(lo, cfg_lo);
    finish_test();
  end
endmodule : tb_top
bind amcd_decoder amcd_props i_amcd_props (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_req_valid(i_req_valid),
  .i_req(i_req), .i_reconfig(i_reconfig), .o_done_valid(o_done_valid), .o_done(o_done), .o_err_code(o_err_code),
  .o_lo_limit(o_lo_limit), .o_hi_limit(o_hi_limit), .o_ramp_mode(o_ramp_mode));
`default_nettype wire
